/* src/sched_pkg.sv */
// constants, register map and tables shared by the egress scheduler files
package sched_pkg;
  localparam int NUM_CLASS = 8;
  localparam int CLS_W = 3;
  localparam logic [2:0] TOP_CLASS = 3'h7;
  localparam int USER_PROF = 8;
  localparam logic [3:0] PROF_FIRST = 4'h1;
  localparam logic [3:0] PROF_LAST_USER = 4'h8;
  localparam logic [3:0] DEF_PROF = 4'h9;
  localparam int LABEL_LEN = 20;
  localparam int CHAR_W = 8;
  localparam logic [4:0] WGT_MIN = 5'h01;
  localparam logic [4:0] WGT_MAX = 5'h14;
  localparam logic [4:0] WGT_RST = 5'h14;
  localparam int WGT_W = 5;
  // levels are held as a 2-bit code: code 0 is level 1, code 3 is level 4
  localparam int LVL_FW = 3;
  localparam logic [2:0] LVL_BASE = 3'h1;
  localparam logic [2:0] LVL_MAX = 3'h4;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [7:0][1:0] DEF_GREEN = {2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0};
  localparam logic [7:0][1:0] YEL_LVL = {2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  localparam int RATE_W = 16;
  localparam int RATE_FRAC = 8;
  localparam int LEN_W = 16;
  localparam int COMP_W = 8;
  localparam int PROF_W = 4;
  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] WORD_MASK = 8'hfc;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PROF = 8'h04;
  localparam logic [7:0] OFF_IFRATE = 8'h08;
  localparam logic [7:0] OFF_COMP = 8'h0c;
  localparam logic [7:0] OFF_IDX = 8'h10;
  localparam logic [7:0] OFF_PRIO = 8'h14;
  localparam logic [7:0] OFF_LABEL = 8'h18;
  localparam logic [7:0] OFF_WGT = 8'h1c;
  localparam logic [7:0] OFF_QRATE = 8'h20;
  localparam logic [7:0] OFF_BRATE = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  // field positions
  localparam int CTRL_HQM = 0;
  localparam int CTRL_IFSH = 1;
  localparam int YEL_LSB = 4;
  localparam int PIR_LSB = 16;
  localparam int IDX_PROF_LSB = 0;
  localparam int IDX_CLS_LSB = 4;
  localparam int IDX_CHR_LSB = 7;
  localparam int CHR_W = 5;
  localparam int IDX_ENT_LSB = 16;
  localparam int ENT_W = 10;
  localparam int STAT_LVL_LSB = 12;
  localparam int STAT_IFB = 16;
  localparam int STAT_GRN = 17;
  localparam int STAT_YEL = 18;
  localparam int STAT_RED = 19;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } wr_st_e;
endpackage : sched_pkg

/* src/shaper_if.sv */
// link between the scheduler and one rate bucket
`timescale 1ns/1ps
interface shaper_if;
  logic enable;
  logic [15:0] rate;
  logic charge;
  logic [15:0] len;
  logic conform;
  modport bucket (input enable, input rate, input charge, input len, output conform);
  modport user (output enable, output rate, output charge, output len, input conform);
endinterface : shaper_if

/* src/token_bucket.sv */
// leaky bucket rate meter: conforms while its level is not negative
`timescale 1ns/1ps
module token_bucket #(
  parameter int LW = 32,
  parameter int BURST_BYTES = 4096
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // scheduler side
  shaper_if.bucket sh
);
  localparam logic signed [LW-1:0] CAP = LW'(BURST_BYTES << sched_pkg::RATE_FRAC);

  typedef struct packed {
    logic signed [LW-1:0] lvl;
  } tb_s;

  tb_s st_r;
  tb_s st_nxt;

  always_comb
  begin
    logic signed [LW-1:0] sum;
    sum = '0;
    st_nxt = st_r;
    if (!sh.enable)
    begin
      // detached meter never limits and starts from a zero level on attach
      st_nxt.lvl = '0;
    end
    else
    begin
      sum = st_r.lvl + $signed(LW'(sh.rate));
      if (sh.charge)
      begin
        sum = sum - $signed(LW'(LW'(sh.len) << sched_pkg::RATE_FRAC));
      end
      st_nxt.lvl = (sum > CAP) ? CAP : sum;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sh.conform = !sh.enable || (st_r.lvl >= 0);
endmodule : token_bucket

/* src/egress_priority_scheduler.sv */
// hierarchical strict-priority and weighted-fair egress scheduler for one interface
// Operation
// - every queue of every bundle is checked for eligibility each cycle
// - higher effective priority always wins over lower
// - equal-priority queues share by per-class weight
// - bundle model repeated for every active bundle, up to 64
// - the interface's attached profile orders classes for all its bundles
// - bundle under committed rate is green
// - bundle over committed but under peak rate is yellow
// - four levels, 4 highest; yellow levels built in
// - green bundle uses the profile's green level per class
// - yellow bundle uses level 1 for classes 0-6, 4 for class 7
// - class 7 always at highest level
// - default profile levels 1,2,2,2,2,3,3,4 for classes 0-7
// - nine profiles; 1-8 writable, 9 fixed and rejects writes
// - interface uses one profile, profile 9 after reset
// - no interface shaper attached means no interface rate limit
// - one line compensation added to every shaper's accounting
// - writable profiles hold level and 20-character label per class
// - interface shaper over peak blocks all interface grants
// - bundle over peak rate gets no grants
// - queue shaper over peak makes its queue ineligible
// - fair share counted in bytes, weights 1 to 20
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module egress_priority_scheduler #(
  parameter int NB = 64,
  parameter int QUANTUM = 128,
  parameter int BURST_BYTES = 4096
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // queue manager
  input wire logic [NB*8-1:0] q_nonempty,
  input wire logic [15:0] frame_len,
  // transmit grant
  output logic grant_valid,
  input wire logic grant_ready,
  output logic [$clog2(NB*8)-1:0] grant_queue,
  output logic [1:0] grant_level
);
  localparam int NQ = NB * sched_pkg::NUM_CLASS;
  localparam int QW = $clog2(NQ);
  localparam int BW = $clog2(NB);
  localparam int CW = 24;

  typedef struct packed {
    sched_pkg::wr_st_e wst;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic hqm;
    logic if_att;
    logic [3:0] prof;
    logic [15:0] if_rate;
    logic [7:0] comp;
    logic [31:0] idx;
    logic [7:0][7:0][1:0] prio;
    logic [63:0][19:0][7:0] lbl;
    logic [7:0][4:0] wgt;
    logic [NQ-1:0][15:0] qrate;
    logic [NB-1:0][31:0] brate;
    logic gv;
    logic [QW-1:0] gq;
    logic [1:0] glvl;
    logic [QW-1:0] ptr;
    logic signed [CW-1:0] cred;
    logic [QW-1:0] lastq;
    logic [1:0] lastlvl;
  } st_s;

  st_s st_r;
  st_s st_nxt;

  logic [NB-1:0] b_green;
  logic [NB-1:0] b_peak_ok;
  logic [NQ-1:0] q_ok;
  logic if_ok;
  logic acc;
  logic [15:0] clen;

  assign acc = st_r.gv && grant_ready;
  assign clen = frame_len + 16'(st_r.comp);

  // green level of a class in profile p; profile 9 is the fixed default
  function automatic logic [1:0] gprio(input st_s s, input logic [3:0] p, input logic [2:0] c);
    if (p == sched_pkg::DEF_PROF)
      return sched_pkg::DEF_GREEN[c];
    return s.prio[3'(p - sched_pkg::PROF_FIRST)][c];
  endfunction : gprio

  function automatic logic user_prof(input logic [3:0] p);
    return (p >= sched_pkg::PROF_FIRST) && (p <= sched_pkg::PROF_LAST_USER);
  endfunction : user_prof

  // register read decode, also used to merge partial-strobe writes
  function automatic logic [33:0] rd(input st_s s, input logic [7:0] a);
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] pf;
    logic [2:0] cl;
    logic [4:0] ch;
    logic [9:0] en;
    d = '0;
    r = sched_pkg::RESP_OKAY;
    pf = s.idx[sched_pkg::IDX_PROF_LSB +: sched_pkg::PROF_W];
    cl = s.idx[sched_pkg::IDX_CLS_LSB +: sched_pkg::CLS_W];
    ch = s.idx[sched_pkg::IDX_CHR_LSB +: sched_pkg::CHR_W];
    en = s.idx[sched_pkg::IDX_ENT_LSB +: sched_pkg::ENT_W];
    case (a & sched_pkg::WORD_MASK)
      sched_pkg::OFF_CTRL:
      begin
        d[sched_pkg::CTRL_HQM] = s.hqm;
        d[sched_pkg::CTRL_IFSH] = s.if_att;
      end
      sched_pkg::OFF_PROF: d[sched_pkg::PROF_W-1:0] = s.prof;
      sched_pkg::OFF_IFRATE: d[sched_pkg::RATE_W-1:0] = s.if_rate;
      sched_pkg::OFF_COMP: d[sched_pkg::COMP_W-1:0] = s.comp;
      sched_pkg::OFF_IDX: d = s.idx;
      sched_pkg::OFF_PRIO:
      begin
        if (user_prof(pf) || pf == sched_pkg::DEF_PROF)
        begin
          d[sched_pkg::LVL_FW-1:0] = 3'(gprio(s, pf, cl)) + sched_pkg::LVL_BASE;
          d[sched_pkg::YEL_LSB +: sched_pkg::LVL_FW] =
            3'(sched_pkg::YEL_LVL[cl]) + sched_pkg::LVL_BASE;
        end
        else
          r = sched_pkg::RESP_SLVERR;
      end
      sched_pkg::OFF_LABEL:
      begin
        if (user_prof(pf) && ch < sched_pkg::LABEL_LEN)
          d[sched_pkg::CHAR_W-1:0] = s.lbl[{3'(pf - sched_pkg::PROF_FIRST), cl}][ch];
        else
          r = sched_pkg::RESP_SLVERR;
      end
      sched_pkg::OFF_WGT: d[sched_pkg::WGT_W-1:0] = s.wgt[cl];
      sched_pkg::OFF_QRATE:
      begin
        if (32'(en) < NQ)
          d[sched_pkg::RATE_W-1:0] = s.qrate[en[QW-1:0]];
        else
          r = sched_pkg::RESP_SLVERR;
      end
      sched_pkg::OFF_BRATE:
      begin
        if (32'(en) < NB)
          d = s.brate[en[BW-1:0]];
        else
          r = sched_pkg::RESP_SLVERR;
      end
      sched_pkg::OFF_STAT:
      begin
        d[QW-1:0] = s.lastq;
        d[sched_pkg::STAT_LVL_LSB +: 2] = s.lastlvl;
        d[sched_pkg::STAT_IFB] = !if_ok;
        if (32'(en) < NB)
        begin
          d[sched_pkg::STAT_GRN] = b_green[en[BW-1:0]];
          d[sched_pkg::STAT_YEL] = !b_green[en[BW-1:0]] && b_peak_ok[en[BW-1:0]];
          d[sched_pkg::STAT_RED] = !b_peak_ok[en[BW-1:0]];
        end
      end
      default: r = sched_pkg::RESP_DECERR;
    endcase
    return {r, d};
  endfunction : rd

  // rate meters: interface, bundle committed and peak, and one per queue
  shaper_if ish();
  token_bucket #(.BURST_BYTES(BURST_BYTES)) u_if_bucket (.clk(clk), .rst_n(rst_n), .sh(ish));
  assign ish.enable = st_r.if_att;
  assign ish.rate = st_r.if_rate;
  assign ish.charge = acc;
  assign ish.len = clen;
  assign if_ok = ish.conform;

  for (genvar b = 0; b < NB; b++)
  begin : g_bundle
    shaper_if csh();
    shaper_if psh();
    token_bucket #(.BURST_BYTES(BURST_BYTES)) u_cir (.clk(clk), .rst_n(rst_n), .sh(csh));
    token_bucket #(.BURST_BYTES(BURST_BYTES)) u_pir (.clk(clk), .rst_n(rst_n), .sh(psh));
    // a bundle with no peak rate has no shaper and stays green
    assign csh.enable = |st_r.brate[b][sched_pkg::PIR_LSB +: sched_pkg::RATE_W];
    assign psh.enable = csh.enable;
    assign csh.rate = st_r.brate[b][sched_pkg::RATE_W-1:0];
    assign psh.rate = st_r.brate[b][sched_pkg::PIR_LSB +: sched_pkg::RATE_W];
    assign csh.charge = acc && (st_r.gq[QW-1:sched_pkg::CLS_W] == BW'(b));
    assign psh.charge = csh.charge;
    assign csh.len = clen;
    assign psh.len = clen;
    assign b_green[b] = csh.conform && (|csh.rate || !csh.enable);
    assign b_peak_ok[b] = psh.conform;
  end

  for (genvar q = 0; q < NQ; q++)
  begin : g_queue
    shaper_if qsh();
    token_bucket #(.BURST_BYTES(BURST_BYTES)) u_q (.clk(clk), .rst_n(rst_n), .sh(qsh));
    assign qsh.enable = |st_r.qrate[q];
    assign qsh.rate = st_r.qrate[q];
    assign qsh.charge = acc && (st_r.gq == QW'(q));
    assign qsh.len = clen;
    assign q_ok[q] = qsh.conform;
  end

  always_comb
  begin
    logic [NQ-1:0] elig;
    logic [NQ-1:0][1:0] lvl;
    logic [NQ-1:0] cand;
    logic [1:0] top;
    logic any;
    logic found;
    logic [QW-1:0] pick;
    logic [QW-1:0] qi;
    logic [BW-1:0] bi;
    logic [2:0] ci;
    logic wr_go;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [33:0] cur;
    logic [1:0] wr;
    logic [3:0] pf;
    logic [2:0] cl;
    logic [4:0] ch;
    logic [9:0] en;
    logic signed [CW-1:0] cr;
    elig = '0;
    lvl = '0;
    cand = '0;
    top = '0;
    any = 1'b0;
    found = 1'b0;
    pick = st_r.ptr;
    qi = '0;
    bi = '0;
    ci = '0;
    cr = '0;
    cur = '0;
    wr = '0;
    wr_go = 1'b0;
    wa = st_r.awa;
    wd = st_r.wd;
    ws = st_r.ws;
    pf = st_r.idx[sched_pkg::IDX_PROF_LSB +: sched_pkg::PROF_W];
    cl = st_r.idx[sched_pkg::IDX_CLS_LSB +: sched_pkg::CLS_W];
    ch = st_r.idx[sched_pkg::IDX_CHR_LSB +: sched_pkg::CHR_W];
    en = st_r.idx[sched_pkg::IDX_ENT_LSB +: sched_pkg::ENT_W];
    st_nxt = st_r;

    // eligibility and effective level of every queue
    for (int q = 0; q < NQ; q++)
    begin
      bi = BW'(q / sched_pkg::NUM_CLASS);
      ci = 3'(q % sched_pkg::NUM_CLASS);
      elig[q] = q_nonempty[q] && q_ok[q] && if_ok && b_peak_ok[bi]
        && (st_r.hqm || bi == '0);
      if (ci == sched_pkg::TOP_CLASS)
        lvl[q] = sched_pkg::LVL_TOP;
      else if (b_green[bi])
        lvl[q] = gprio(st_r, st_r.prof, ci);
      else
        lvl[q] = sched_pkg::YEL_LVL[ci];
      if (elig[q] && (!any || lvl[q] > top))
        top = lvl[q];
      any = any | elig[q];
    end
    for (int q = 0; q < NQ; q++)
      cand[q] = elig[q] && (lvl[q] == top);
    // first candidate at or after the fairness pointer
    for (int i = 0; i < NQ; i++)
    begin
      qi = st_r.ptr + QW'(i);
      if (!found && cand[qi])
      begin
        found = 1'b1;
        pick = qi;
      end
    end

    // grant offer and byte-based fairness credit
    if (acc)
    begin
      st_nxt.gv = 1'b0;
      st_nxt.lastq = st_r.gq;
      st_nxt.lastlvl = st_r.glvl;
      if (st_r.gq != st_r.ptr)
        cr = CW'(32'(st_r.wgt[st_r.gq[2:0]]) * QUANTUM) - $signed(CW'(clen));
      else
        cr = st_r.cred - $signed(CW'(clen));
      st_nxt.cred = cr;
      st_nxt.ptr = (cr > 0) ? st_r.gq : st_r.gq + QW'(1);
    end
    else if (!st_r.gv && any)
    begin
      // offer is registered and held until taken, so it can lag one cycle
      st_nxt.gv = 1'b1;
      st_nxt.gq = pick;
      st_nxt.glvl = top;
    end

    // read channel
    if (st_r.rv && rready)
      st_nxt.rv = 1'b0;
    if (!st_r.rv && arvalid)
    begin
      cur = rd(st_r, araddr);
      st_nxt.rv = 1'b1;
      st_nxt.rd = cur[31:0];
      st_nxt.rr = cur[33:32];
    end

    // write channel: address and data are taken in either order
    case (st_r.wst)
      sched_pkg::WR_IDLE:
      begin
        wa = awaddr;
        wd = wdata;
        ws = wstrb;
        if (awvalid && wvalid)
          wr_go = 1'b1;
        else if (awvalid)
        begin
          st_nxt.awa = awaddr;
          st_nxt.wst = sched_pkg::WR_ADDR;
        end
        else if (wvalid)
        begin
          st_nxt.wd = wdata;
          st_nxt.ws = wstrb;
          st_nxt.wst = sched_pkg::WR_DATA;
        end
      end
      sched_pkg::WR_ADDR:
      begin
        wd = wdata;
        ws = wstrb;
        wr_go = wvalid;
      end
      sched_pkg::WR_DATA:
      begin
        wa = awaddr;
        wr_go = awvalid;
      end
      sched_pkg::WR_RESP:
      begin
        if (bready)
        begin
          st_nxt.bv = 1'b0;
          st_nxt.wst = sched_pkg::WR_IDLE;
        end
      end
      default: st_nxt.wst = sched_pkg::WR_IDLE;
    endcase

    cur = rd(st_r, wa);
    for (int l = 0; l < 4; l++)
    begin
      if (ws[l])
        cur[8*l +: 8] = wd[8*l +: 8];
    end
    wr = cur[33:32];
    if (wr_go)
    begin
      st_nxt.wst = sched_pkg::WR_RESP;
      st_nxt.bv = 1'b1;
      if (wr == sched_pkg::RESP_OKAY)
      begin
        case (wa & sched_pkg::WORD_MASK)
          sched_pkg::OFF_CTRL:
          begin
            st_nxt.hqm = cur[sched_pkg::CTRL_HQM];
            st_nxt.if_att = cur[sched_pkg::CTRL_IFSH];
          end
          sched_pkg::OFF_PROF:
          begin
            if (user_prof(cur[3:0]) || cur[3:0] == sched_pkg::DEF_PROF)
              st_nxt.prof = cur[sched_pkg::PROF_W-1:0];
            else
              wr = sched_pkg::RESP_SLVERR;
          end
          sched_pkg::OFF_IFRATE: st_nxt.if_rate = cur[sched_pkg::RATE_W-1:0];
          sched_pkg::OFF_COMP: st_nxt.comp = cur[sched_pkg::COMP_W-1:0];
          sched_pkg::OFF_IDX: st_nxt.idx = cur[31:0];
          sched_pkg::OFF_PRIO:
          begin
            // profile 9 is fixed and the level must be 1 to 4
            if (user_prof(pf) && cur[2:0] >= sched_pkg::LVL_BASE
                && cur[2:0] <= sched_pkg::LVL_MAX)
              st_nxt.prio[3'(pf - sched_pkg::PROF_FIRST)][cl] =
                2'(cur[2:0] - sched_pkg::LVL_BASE);
            else
              wr = sched_pkg::RESP_SLVERR;
          end
          sched_pkg::OFF_LABEL:
            st_nxt.lbl[{3'(pf - sched_pkg::PROF_FIRST), cl}][ch] =
              cur[sched_pkg::CHAR_W-1:0];
          sched_pkg::OFF_WGT:
          begin
            if (cur[4:0] >= sched_pkg::WGT_MIN && cur[4:0] <= sched_pkg::WGT_MAX
                && cur[31:sched_pkg::WGT_W] == '0)
              st_nxt.wgt[cl] = cur[sched_pkg::WGT_W-1:0];
            else
              wr = sched_pkg::RESP_SLVERR;
          end
          sched_pkg::OFF_QRATE: st_nxt.qrate[en[QW-1:0]] = cur[sched_pkg::RATE_W-1:0];
          sched_pkg::OFF_BRATE: st_nxt.brate[en[BW-1:0]] = cur[31:0];
          default: wr = sched_pkg::RESP_SLVERR;
        endcase
      end
      st_nxt.br = wr;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.prof <= sched_pkg::DEF_PROF;
      for (int c = 0; c < sched_pkg::NUM_CLASS; c++)
        st_r.wgt[c] <= sched_pkg::WGT_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign awready = (st_r.wst == sched_pkg::WR_IDLE) || (st_r.wst == sched_pkg::WR_DATA);
  assign wready = (st_r.wst == sched_pkg::WR_IDLE) || (st_r.wst == sched_pkg::WR_ADDR);
  assign bvalid = st_r.bv;
  assign bresp = st_r.br;
  assign arready = !st_r.rv;
  assign rvalid = st_r.rv;
  assign rdata = st_r.rd;
  assign rresp = st_r.rr;
  assign grant_valid = st_r.gv;
  assign grant_queue = st_r.gq;
  assign grant_level = st_r.glvl;
endmodule : egress_priority_scheduler

/* verification/egress_priority_scheduler_sva.sv */
// port-level assertions for the egress scheduler
`timescale 1ns/1ps
module egress_priority_scheduler_sva #(
  parameter int NB = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // queues and grant stream
  input wire logic [NB*8-1:0] q_nonempty,
  input wire logic grant_valid,
  input wire logic grant_ready,
  input wire logic [$clog2(NB*8)-1:0] grant_queue,
  input wire logic [1:0] grant_level
);
  // queue state one cycle back: an offer is decided from the previous cycle
  logic [NB*8-1:0] q_r;
  always_ff @(posedge clk) q_r <= q_nonempty;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_offer_hold: assert property (
    grant_valid && !grant_ready |=> grant_valid && $stable(grant_queue) && $stable(grant_level))
    else $error("grant offer changed while waiting");
  chk_accept_drop: assert property (grant_valid && grant_ready |=> !grant_valid)
    else $error("offer not withdrawn after accept");
  chk_offer_source: assert property ($rose(grant_valid) |-> q_r[grant_queue])
    else $error("offered queue had no frame");
  chk_top_class: assert property (
    grant_valid && grant_queue[2:0] == 3'h7 |-> grant_level == 2'h3)
    else $error("top class not at highest level");
  chk_idle_nogrant: assert property (
    !grant_valid && q_nonempty == '0 |=> !grant_valid)
    else $error("grant with no queue filled");
  chk_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_write_resp: assert property (
    awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response late");
  chk_read_turn: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_read_busy: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
endmodule : egress_priority_scheduler_sva

/* verification/egress_port_model.sv */
// egress port model: takes grant offers promptly or with random stalls
`timescale 1ns/1ps
module egress_port_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench control
  input wire logic slow,
  input wire logic [15:0] len,
  // grant stream
  input wire logic grant_valid,
  output logic grant_ready,
  output logic [15:0] frame_len
);
  always @(posedge clk)
  begin
    grant_ready <= rst_n && (!slow || $urandom_range(1, 0) == 1);
  end
  // length only means something at accept; show garbage otherwise
  assign frame_len = (grant_valid && grant_ready) ? len : ~len;
endmodule : egress_port_model

/* verification/egress_priority_scheduler_tb.sv */
// self-checking bench for the egress scheduler
`timescale 1ns/1ps
module egress_priority_scheduler_tb;
  localparam int NB = 2;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, slow;
  logic awready, wready, bvalid, arready, rvalid, grant_valid, grant_ready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, grant_queue;
  logic [1:0] bresp, rresp, grant_level;
  logic [15:0] q_nonempty, frame_len, len;
  logic [2:0] lv [8] = '{3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
  logic [31:0] modes [3] = '{32'hffff_0000, 32'hffff_ffff, 32'h0};
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  logic [17:0] exp_g [$];
  logic [17:0] g;
  int num_errors = 0;
  int n_checks = 0;
  egress_priority_scheduler #(.NB(NB), .QUANTUM(16), .BURST_BYTES(4096)) u_dut (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .q_nonempty(q_nonempty),
    .frame_len(frame_len), .grant_valid(grant_valid), .grant_ready(grant_ready),
    .grant_queue(grant_queue), .grant_level(grant_level));
  egress_port_model u_port (.clk(clk), .rst_n(rst_n), .slow(slow), .len(len),
    .grant_valid(grant_valid), .grant_ready(grant_ready), .frame_len(frame_len));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ad = 1'b0;
    bit dd = 1'b0;
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      ad = ad || awready;
      dd = dd || wready;
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
  endtask : rd
  function automatic logic [31:0] idx(int prof, int cls, int chr);
    return (32'(chr) << 7) | (32'(cls) << 4) | 32'(prof);
  endfunction : idx
  function automatic logic [1:0] elvl(int c, bit yel);
    if (c == 7) return 2'h3;
    if (yel) return 2'h0;
    return 2'(lv[c] - 3'h1);
  endfunction : elvl
  task automatic trials(int n, bit wide, bit yel);
    logic [15:0] m;
    logic [1:0] best;
    repeat (n)
    begin
      m = 16'($urandom);
      if (!wide) m[15:8] = 8'h00;
      if (m == 16'h0000) m = 16'h0001;
      best = 2'h0;
      for (int i = 0; i < 16; i++)
        if (m[i] && elvl(i % 8, yel) > best) best = elvl(i % 8, yel);
      exp_g.push_back({m, best});
      q_nonempty <= m;
      do @(posedge clk); while (!(grant_valid && grant_ready));
    end
    q_nonempty <= 16'h0000;
  endtask : trials
  always @(posedge clk)
  begin
    if (rst_n && bvalid && bready) check(bresp, exp_b.pop_front());
    if (rst_n && rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
    if (rst_n && grant_valid && grant_ready)
    begin
      g = exp_g.pop_front();
      check(grant_level, g[1:0]);
      check(g[grant_queue + 2], 1'b1);
    end
  end
  task final_report;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial
  begin
    {rst_n, awvalid, wvalid, arvalid, slow, awaddr, araddr, wdata} = '0;
    {bready, rready, wstrb, q_nonempty, len} = {2'h3, 4'hf, 16'h0, 16'h0040};
    void'($urandom(32'h6489));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(sched_pkg::OFF_PROF, 32'h9, sched_pkg::RESP_OKAY);
    for (int c = 0; c < 8; c++)
    begin
      wr(sched_pkg::OFF_IDX, idx(9, c, 0), sched_pkg::RESP_OKAY);
      rd(sched_pkg::OFF_PRIO, {25'h0, (c == 7) ? 3'h4 : 3'h1, 1'b0, lv[c]}, 2'h0);
    end
    wr(sched_pkg::OFF_PRIO, 32'h4, sched_pkg::RESP_SLVERR);
    wr(sched_pkg::OFF_PROF, 32'ha, sched_pkg::RESP_SLVERR);
    wr(sched_pkg::OFF_STAT, 32'h0, sched_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, sched_pkg::RESP_DECERR);
    rd(sched_pkg::OFF_PROF, 32'h9, sched_pkg::RESP_OKAY);
    // standard mode: a second bundle must stay silent
    q_nonempty <= 16'hff00;
    repeat (40) @(posedge clk);
    trials(20, 1'b0, 1'b0);
    wr(sched_pkg::OFF_CTRL, 32'h1, sched_pkg::RESP_OKAY);
    trials(20, 1'b1, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      lv[c] = (c == 7) ? 3'h1 : 3'(1 + $urandom_range(3, 0));
      wr(sched_pkg::OFF_IDX, idx(1, c, 19), sched_pkg::RESP_OKAY);
      wr(sched_pkg::OFF_PRIO, 32'(lv[c]), sched_pkg::RESP_OKAY);
      rd(sched_pkg::OFF_PRIO, {25'h0, (c == 7) ? 3'h4 : 3'h1, 1'b0, lv[c]}, 2'h0);
    end
    wr(sched_pkg::OFF_LABEL, 32'h41, sched_pkg::RESP_OKAY);
    rd(sched_pkg::OFF_LABEL, 32'h41, 2'h0);
    wr(sched_pkg::OFF_IDX, idx(1, 0, 20), sched_pkg::RESP_OKAY);
    wr(sched_pkg::OFF_LABEL, 32'h41, sched_pkg::RESP_SLVERR);
    wr(sched_pkg::OFF_PROF, 32'h1, sched_pkg::RESP_OKAY);
    trials(20, 1'b1, 1'b0);
    slow <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      wr(sched_pkg::OFF_BRATE, modes[i], sched_pkg::RESP_OKAY);
      repeat (8) @(posedge clk);
      trials(15, 1'b0, i == 0);
    end
    // one long frame drains the interface bucket
    len <= 16'd1000;
    wr(sched_pkg::OFF_CTRL, 32'h3, sched_pkg::RESP_OKAY);
    wr(sched_pkg::OFF_IFRATE, 32'h1, sched_pkg::RESP_OKAY);
    exp_g.push_back({16'h0001, elvl(0, 1'b0)});
    q_nonempty <= 16'h0001;
    repeat (200) @(posedge clk);
    check(34'(exp_g.size()), 34'h0);
    rd(sched_pkg::OFF_STAT, 32'h30000 | 32'(elvl(0, 1'b0)) << 12, 2'h0);
    q_nonempty <= 16'h0000;
    wr(sched_pkg::OFF_CTRL, 32'h1, sched_pkg::RESP_OKAY);
    trials(4, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    final_report();
  end
endmodule : egress_priority_scheduler_tb
bind egress_priority_scheduler egress_priority_scheduler_sva #(.NB(NB)) u_sva (
  .clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .q_nonempty(q_nonempty), .grant_valid(grant_valid), .grant_ready(grant_ready),
  .grant_queue(grant_queue), .grant_level(grant_level));
